// file: include/rotate_mask_pkg.sv
// constants, field layout and register map of the rotate-and-mask unit
package rotate_mask_pkg;
   // data path shape
   localparam int DataWidth = 32;
   localparam int IndexWidth = 5;
   localparam int RegCount = 32;
   localparam int AddrWidth = 8;

   // register byte offsets
   localparam logic [7:0] InstrOfs = 8'h00;
   localparam logic [7:0] CondOfs = 8'h04;
   localparam logic [7:0] ExcOfs = 8'h08;
   localparam logic [7:0] StatusOfs = 8'h0C;
   localparam logic [7:0] GprBaseOfs = 8'h80;

   // instruction word field positions, lsb of each field (msb is word bit 31)
   localparam int OpcodeLsb = 26;
   localparam int SourceLsb = 21;
   localparam int DestLsb = 16;
   localparam int AmountLsb = 11;
   localparam int StartLsb = 6;
   localparam int StopLsb = 1;
   localparam int RecordBit = 0;
   localparam int OpcodeWidth = 6;

   // primary opcodes
   localparam logic [5:0] OpRotImm = 6'h15;
   localparam logic [5:0] OpRotReg = 6'h17;

   // condition field 0 bit positions
   localparam int CondLessBit = 3;
   localparam int CondGreaterBit = 2;
   localparam int CondZeroBit = 1;
   localparam int CondSumOvBit = 0;

   // exception register: summary overflow is its most significant bit
   localparam int ExcSumOvBit = 31;

   // status register bits
   localparam int StatBusyBit = 0;
   localparam int StatIllegalBit = 1;

   // reset values
   localparam logic [31:0] InstrRst = 32'h0000_0000;
   localparam logic [3:0] CondRst = 4'h0;
   localparam logic [31:0] ExcRst = 32'h0000_0000;
   localparam logic [31:0] GprRst = 32'h0000_0000;

   // execution sequencer states
   typedef enum logic [0:0] {
      StIdle = 1'b0,
      StExec = 1'b1
   } exec_state_t;
endpackage : rotate_mask_pkg

// file: rtl/mask_generator.sv
// wrap-around mask built from a start and a stop index, msb-first numbering
`timescale 1ns/10ps
`default_nettype none
module mask_generator
   import rotate_mask_pkg::*;
#(
   parameter int Width = DataWidth,
   parameter int IdxWidth = IndexWidth
) (
   // mask bounds, position 0 is the word's msb
   input wire logic [IdxWidth-1:0] startIdx,
   input wire logic [IdxWidth-1:0] stopIdx,
   // generated mask
   output logic [Width-1:0] mask
);
   logic [IdxWidth:0] stopPlusOne;
   logic [IdxWidth:0] startWide;
   logic plainRun;
   logic fullMask;

   // compare start against stop plus one without wrapping
   assign stopPlusOne = {1'b0, stopIdx} + {{IdxWidth{1'b0}}, 1'b1};
   assign startWide = {1'b0, startIdx};
   assign plainRun = startWide < stopPlusOne;
   assign fullMask = startWide == stopPlusOne;

   // one decision per mask position
   for (genvar p = 0; p < Width; p++) begin : g_bit
      logic [IdxWidth:0] pos;
      logic inRun;
      logic inGap;
      assign pos = (IdxWidth + 1)'(p);
      assign inRun = (pos >= startWide) && (pos <= {1'b0, stopIdx});
      assign inGap = (pos >= stopPlusOne) && (pos < startWide);
      assign mask[Width-1-p] = plainRun ? inRun :
                               fullMask ? 1'b1 :
                               !inGap;
   end
endmodule : mask_generator
`default_nettype wire

// file: rtl/rotate_mask_unit.sv
// rotate-left-then-mask execution unit with its register file, reached over apb
//
// What this block does
// - The immediate form rotates the 32-bit source word left by the immediate amount before masking.
// - The register form takes its rotate amount from the count register's bits 0-4 and ignores the rest.
// - The rotated word is ANDed with the mask and written whole to the destination, zero outside the mask.
// - With start below stop plus one the mask is ones from start to stop inclusive and zeros elsewhere.
// - With start equal to stop plus one all 32 mask positions are ones.
// - With start above stop plus one positions stop+1 through start-1 are zeros and the rest ones.
// - Record flag clear leaves condition field 0 alone; set, its four bits are updated.
// - In the record form the field shows negative, positive or zero of the signed result.
// - In the record form the summary overflow status is copied into the field.
// - No form ever changes any bit of the exception register.
`timescale 1ns/10ps
`default_nettype none
module rotate_mask_unit
   import rotate_mask_pkg::*;
#(
   parameter int Width = DataWidth,
   parameter int NumRegs = RegCount
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [AddrWidth-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // execution side outputs
   output logic execDone,
   output logic [3:0] condField
);
   // apb handshake state
   logic waitDoneQ;
   logic accessPhase;
   logic complete;
   logic wrDone;
   logic isGpr;
   logic mapped;
   logic [IndexWidth-1:0] gprIdx;
   logic [31:0] rdDataD;
   logic [31:0] rdDataQ;

   // software visible state
   logic [31:0] instrQ;
   logic [3:0] condQ;
   logic [31:0] excQ;
   logic illegalQ;
   logic [Width-1:0] gprQ [NumRegs];
   logic execDoneQ;

   // sequencer
   exec_state_t stateQ;
   exec_state_t stateD;

   // decoded instruction fields
   logic [OpcodeWidth-1:0] opcode;
   logic [IndexWidth-1:0] sourceRegister;
   logic [IndexWidth-1:0] destinationReg;
   logic [IndexWidth-1:0] amountField;
   logic [IndexWidth-1:0] maskStartIndex;
   logic [IndexWidth-1:0] maskStopIndex;
   logic recordFlag;
   logic isImm;
   logic isReg;
   logic legal;

   // datapath
   logic [Width-1:0] srcWord;
   logic [Width-1:0] countWord;
   logic [IndexWidth-1:0] rotAmount;
   logic [2*Width-1:0] rotWide;
   logic [Width-1:0] rotated;
   logic [Width-1:0] mask;
   logic [Width-1:0] result;
   logic lessThanFlag;
   logic greaterThanFlag;
   logic zeroResultFlag;
   logic [3:0] condNew;

   // ------------------------------------------------------------------
   // bus decode: every access takes one wait cycle so that read data
   // is captured from flops after any execution triggered earlier
   // ------------------------------------------------------------------
   assign accessPhase = psel && penable;
   assign complete = accessPhase && waitDoneQ;
   assign wrDone = complete && pwrite && mapped;
   assign isGpr = paddr[AddrWidth-1];
   assign gprIdx = paddr[IndexWidth+1:2];

   // address map check, misaligned words count as unmapped
   always_comb begin
      mapped = 1'b0;
      if (paddr[1:0] == 2'b00) begin
         if (isGpr) begin
            mapped = 1'b1;
         end else begin
            case (paddr)
               InstrOfs, CondOfs, ExcOfs, StatusOfs: mapped = 1'b1;
               default: mapped = 1'b0;
            endcase
         end
      end
   end

   // handshake outputs
   assign pready = complete;
   assign pslverr = complete && !mapped;
   assign prdata = rdDataQ;

   // wait-state toggle: low on the first access cycle, high on the second
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         waitDoneQ <= 1'b0;
      end else if (complete || !accessPhase) begin
         waitDoneQ <= 1'b0;
      end else begin
         waitDoneQ <= 1'b1;
      end
   end

   // read multiplexer
   always_comb begin
      rdDataD = 32'h0000_0000;
      if (mapped && !pwrite) begin
         if (isGpr) begin
            rdDataD = gprQ[gprIdx];
         end else begin
            case (paddr)
               InstrOfs: rdDataD = instrQ;
               CondOfs: rdDataD = {28'h000_0000, condQ};
               ExcOfs: rdDataD = excQ;
               StatusOfs: begin
                  rdDataD[StatBusyBit] = stateQ == StExec;
                  rdDataD[StatIllegalBit] = illegalQ;
               end
               default: rdDataD = 32'h0000_0000;
            endcase
         end
      end
   end

   // read data captured in the wait cycle and held through completion
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdDataQ <= 32'h0000_0000;
      end else if (accessPhase && !waitDoneQ) begin
         rdDataQ <= rdDataD;
      end
   end

   // ------------------------------------------------------------------
   // instruction decode, fields numbered from the msb
   // ------------------------------------------------------------------
   assign opcode = instrQ[OpcodeLsb +: OpcodeWidth];
   assign sourceRegister = instrQ[SourceLsb +: IndexWidth];
   assign destinationReg = instrQ[DestLsb +: IndexWidth];
   assign amountField = instrQ[AmountLsb +: IndexWidth];
   assign maskStartIndex = instrQ[StartLsb +: IndexWidth];
   assign maskStopIndex = instrQ[StopLsb +: IndexWidth];
   assign recordFlag = instrQ[RecordBit];
   assign isImm = opcode == OpRotImm;
   assign isReg = opcode == OpRotReg;
   assign legal = isImm || isReg;

   // ------------------------------------------------------------------
   // datapath: rotate, mask, compare
   // ------------------------------------------------------------------
   assign srcWord = gprQ[sourceRegister];
   assign countWord = gprQ[amountField];

   // amount from the immediate or from the count register's low five bits
   assign rotAmount = isReg ? countWord[IndexWidth-1:0] : amountField;

   // rotate left by doubling the word and taking the upper half
   assign rotWide = {srcWord, srcWord} << rotAmount;
   assign rotated = rotWide[2*Width-1:Width];

   mask_generator #(
      .Width(Width),
      .IdxWidth(IndexWidth)
   ) u_mask (
      .startIdx(maskStartIndex),
      .stopIdx(maskStopIndex),
      .mask(mask)
   );

   // bits outside the mask come out zero
   assign result = rotated & mask;

   // signed compare of the result against zero
   assign lessThanFlag = result[Width-1];
   assign zeroResultFlag = result == '0;
   assign greaterThanFlag = !lessThanFlag && !zeroResultFlag;

   // new condition field with the summary overflow copied in
   always_comb begin
      condNew = CondRst;
      condNew[CondLessBit] = lessThanFlag;
      condNew[CondGreaterBit] = greaterThanFlag;
      condNew[CondZeroBit] = zeroResultFlag;
      condNew[CondSumOvBit] = excQ[ExcSumOvBit];
   end

   // ------------------------------------------------------------------
   // sequencer: a write to the instruction register starts one execution
   // ------------------------------------------------------------------
   always_comb begin
      stateD = stateQ;
      case (stateQ)
         StIdle: begin
            if (wrDone && !isGpr && paddr == InstrOfs) begin
               stateD = StExec;
            end
         end
         StExec: stateD = StIdle;
         default: stateD = StIdle;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stateQ <= StIdle;
      end else begin
         stateQ <= stateD;
      end
   end

   // instruction register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         instrQ <= InstrRst;
      end else if (wrDone && !isGpr && paddr == InstrOfs) begin
         instrQ <= pwdata;
      end
   end

   // exception register: software only, execution never writes it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         excQ <= ExcRst;
      end else if (wrDone && !isGpr && paddr == ExcOfs) begin
         excQ <= pwdata;
      end
   end

   // condition field 0: updated by a recording execution or a software write, execution wins
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         condQ <= CondRst;
      end else if (stateQ == StExec && legal && recordFlag) begin
         condQ <= condNew;
      end else if (wrDone && !isGpr && paddr == CondOfs) begin
         condQ <= pwdata[3:0];
      end
   end

   // sticky illegal-opcode flag, write one to clear, a new event wins
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         illegalQ <= 1'b0;
      end else if (stateQ == StExec && !legal) begin
         illegalQ <= 1'b1;
      end else if (wrDone && !isGpr && paddr == StatusOfs && pwdata[StatIllegalBit]) begin
         illegalQ <= 1'b0;
      end
   end

   // general purpose registers, execution write-back has priority
   for (genvar r = 0; r < NumRegs; r++) begin : g_gpr
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            gprQ[r] <= GprRst;
         end else if (stateQ == StExec && legal && destinationReg == IndexWidth'(r)) begin
            gprQ[r] <= result;
         end else if (wrDone && isGpr && gprIdx == IndexWidth'(r)) begin
            gprQ[r] <= pwdata;
         end
      end
   end

   // completion pulse, one cycle after the execute cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         execDoneQ <= 1'b0;
      end else begin
         execDoneQ <= stateQ == StExec && legal;
      end
   end

   assign execDone = execDoneQ;
   assign condField = condQ;
endmodule : rotate_mask_unit
`default_nettype wire

// file: tb/rotate_mask_unit_assertions.sv
// port-level checks of the rotate-and-mask unit
`timescale 1ns/10ps
`default_nettype none
module rotate_mask_unit_assertions
   import rotate_mask_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [AddrWidth-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // execution
   input wire logic execDone,
   input wire logic [3:0] condField
);
   logic instrWr;
   logic legalWr;
   logic recQ;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // completed instruction write and whether its opcode is executable
   assign instrWr = psel && penable && pready && pwrite && paddr == InstrOfs;
   assign legalWr = instrWr && (pwdata[31:26] == OpRotImm || pwdata[31:26] == OpRotReg);
   // record bit of the last instruction issued
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         recQ <= 1'h0;
      end else if (instrWr) begin
         recQ <= pwdata[RecordBit];
      end
   end
   a_ready_pulse: assert property (pready |=> !pready) else $error("pready held over one cycle");
   a_ready_sel: assert property (pready |-> psel && penable) else $error("pready outside access phase");
   a_one_wait: assert property (psel && penable && $past(psel) && !$past(penable) |-> !pready ##1 pready)
      else $error("access phase not exactly two cycles");
   a_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
   a_bad_addr: assert property (pready && (paddr[1:0] != 2'h0 || (paddr >= 8'h10 && paddr < 8'h80)) |-> pslverr)
      else $error("unmapped access not refused");
   a_done_after: assert property (legalWr |-> ##2 execDone) else $error("execDone late or missing");
   a_done_cause: assert property (execDone |-> $past(legalWr, 2)) else $error("execDone without instruction");
   a_cond_kept: assert property (instrWr && !pwdata[RecordBit] |=> $stable(condField)[*3])
      else $error("condition field moved without record");
   a_cond_sign: assert property (execDone && recQ |=> $onehot(condField[3:1]))
      else $error("condition field not one sign flag");
   a_refused_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
      else $error("refused read returned data");
   c_record: cover property (execDone && recQ);
   c_plain: cover property (execDone && !recQ);
   c_refused: cover property (pslverr);
endmodule : rotate_mask_unit_assertions
bind rotate_mask_unit rotate_mask_unit_assertions u_chk (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .execDone(execDone), .condField(condField));
`default_nettype wire

// file: tb/apb_master_model.sv
// apb master standing in for the decoder and register-file side
`timescale 1ns/10ps
`default_nettype none
module apb_master_model
   import rotate_mask_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // request from the bench
   input wire logic go,
   input wire logic wr,
   input wire logic [AddrWidth-1:0] addr,
   input wire logic [31:0] wdata,
   // result to the bench
   output logic done,
   output logic [31:0] rdata,
   output logic err,
   // apb master pins
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [AddrWidth-1:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // setup, access held until pready, then release with idle lines scrambled
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         psel <= 1'h0;
         penable <= 1'h0;
         pwrite <= 1'h0;
         paddr <= 8'h00;
         pwdata <= 32'h0;
         done <= 1'h0;
      end else begin
         done <= 1'h0;
         if (psel && penable && pready) begin
            psel <= 1'h0;
            penable <= 1'h0;
            paddr <= ~paddr;
            pwdata <= ~pwdata;
            rdata <= prdata;
            err <= pslverr;
            done <= 1'h1;
         end else if (psel) begin
            penable <= 1'h1;
         end else if (go) begin
            psel <= 1'h1;
            pwrite <= wr;
            paddr <= addr;
            pwdata <= wdata;
         end
      end
   end
endmodule : apb_master_model
`default_nettype wire

// file: tb/rotate_and_mask_unit_tb_top.sv
// self-checking bench for the rotate-and-mask unit, random instructions
`timescale 1ns/10ps
`default_nettype none
module rotate_and_mask_unit_tb_top
   import rotate_mask_pkg::*;
;
   logic clk, rst, go, wr, done, err, psel, penable, pwrite, pready, pslverr, execDone;
   logic [7:0] addr, paddr;
   logic [31:0] wdata, rdata, pwdata, prdata;
   logic [3:0] condField;
   logic [31:0] gm [32];
   logic [4:0] cmb [4] = '{5'h03, 5'h0B, 5'h1F, 5'h00};
   logic [4:0] cme [4] = '{5'h14, 5'h0A, 5'h00, 5'h1F};
   int mismatches = 0;
   int nTests = 0;
   int nDone = 0;
   rotate_mask_unit dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .execDone(execDone),
      .condField(condField));
   apb_master_model u_host (.clk(clk), .rst(rst), .go(go), .wr(wr), .addr(addr), .wdata(wdata), .done(done),
      .rdata(rdata), .err(err), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));
   // expected mask, position p is word bit 31-p
   function automatic logic [31:0] expMask(input logic [4:0] mStart, input logic [4:0] mStop);
      logic [31:0] m;
      for (int p = 0; p < 32; p++) begin
         m[31-p] = (mStart <= mStop) ? (p >= mStart && p <= mStop) : !(p > mStop && p < mStart);
      end
      return m;
   endfunction : expMask
   function automatic logic [31:0] rotl(input logic [31:0] x, input logic [4:0] n);
      logic [63:0] w;
      w = {x, x} << n;
      return w[63:32];
   endfunction : rotl
   function automatic logic [7:0] gprA(input logic [4:0] i);
      return GprBaseOfs + {1'h0, i, 2'h0};
   endfunction : gprA
   task automatic testDone();
      if (mismatches == 0 && nTests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : testDone
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      nTests++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   // one transfer through the host model after a random gap, bounded wait
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] dat);
      int t;
      t = 0;
      repeat ($urandom_range(2)) @(posedge clk);
      @(posedge clk);
      go <= 1'h1;
      wr <= w;
      addr <= a;
      wdata <= dat;
      @(posedge clk);
      go <= 1'h0;
      @(negedge clk);
      while (done !== 1'h1 && t < 50) begin
         @(negedge clk);
         t++;
      end
      if (t >= 50) begin
         mismatches++;
         testDone();
      end
   endtask : xfer
   // count completion pulses, one per legal instruction
   always @(posedge clk) begin
      if (execDone === 1'h1) begin
         nDone <= nDone + 1;
      end
   end
   // free-running clock
   initial begin
      clk = 1'h0;
      forever #20 clk = ~clk;
   end
   // hang guard
   initial begin
      repeat (10000) @(posedge clk);
      mismatches++;
      testDone();
   end
   // main sequence
   initial begin : mainSeq
      logic [5:0] op;
      logic [4:0] s, d, a, mStart, mStop;
      logic rec;
      logic [31:0] sv, cv, exc, res;
      logic [3:0] cexp;
      go = 1'h0;
      wr = 1'h0;
      addr = 8'h00;
      wdata = 32'h0;
      rst = 1'h1;
      cexp = 4'h0;
      void'($urandom(32'hB0AA3C05));
      repeat (2) @(posedge clk);
      rst <= 1'h0;
      xfer(1'h0, ExcOfs, 32'h0);
      check(rdata, 32'h0);
      for (int i = 0; i < 40; i++) begin
         op = $urandom_range(1) ? OpRotReg : OpRotImm;
         s = 5'($urandom);
         d = 5'($urandom);
         a = 5'($urandom);
         mStart = (i < 4) ? cmb[i] : 5'($urandom);
         mStop = (i < 4) ? cme[i] : 5'($urandom);
         rec = 1'($urandom);
         exc = $urandom;
         sv = $urandom;
         cv = $urandom;
         xfer(1'h1, ExcOfs, exc);
         xfer(1'h1, gprA(s), sv);
         gm[s] = sv;
         xfer(1'h1, gprA(a), cv);
         gm[a] = cv;
         res = rotl(gm[s], (op == OpRotImm) ? a : gm[a][4:0]) & expMask(mStart, mStop);
         xfer(1'h1, InstrOfs, {op, s, d, a, mStart, mStop, rec});
         gm[d] = res;
         if (rec) cexp = {res[31], !res[31] && res != 32'h0, res == 32'h0, exc[31]};
         xfer(1'h0, gprA(d), 32'h0);
         check(rdata, res);
         check({28'h0, condField}, {28'h0, cexp});
         xfer(1'h0, ExcOfs, 32'h0);
         check(rdata, exc);
      end
      // unknown opcode must leave destination and condition alone; preload values no execution yields
      xfer(1'h1, gprA(d), ~gm[d]);
      gm[d] = ~gm[d];
      xfer(1'h1, CondOfs, 32'h0000_000E);
      cexp = 4'hE;
      xfer(1'h1, InstrOfs, {6'h00, s, d, a, mStart, mStop, 1'h1});
      xfer(1'h0, gprA(d), 32'h0);
      check(rdata, gm[d]);
      check({28'h0, condField}, {28'h0, cexp});
      xfer(1'h0, StatusOfs, 32'h0);
      check({31'h0, rdata[StatIllegalBit]}, 32'h1);
      check(nDone, 32'h28);
      // illegal flag clears on a write of one
      xfer(1'h1, StatusOfs, 32'h0000_0002);
      xfer(1'h0, StatusOfs, 32'h0);
      check({31'h0, rdata[StatIllegalBit]}, 32'h0);
      // unmapped address is refused and reads zero
      xfer(1'h0, 8'h40, 32'h0);
      check({31'h0, err}, 32'h1);
      check(rdata, 32'h0);
      testDone();
   end
endmodule : rotate_and_mask_unit_tb_top
`default_nettype wire
